//--- split_intr_pkg.sv
// Constants for the split interrupt descriptor decoder.
// Shared by the decoder and by whatever sits beside it on the bus.
package split_intr_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] LENGTH_AND_VALID_OFS = 8'h00;
	localparam logic [7:0] ROUTING_AND_TOKEN_OFS = 8'h04;
	localparam logic [7:0] BUFFER_AND_INTERVAL_OFS = 8'h08;
	localparam logic [7:0] TRANSFER_STATUS_OFS = 8'h0C;

	// Length and valid word fields
	localparam int VALID_BIT = 0;
	localparam int BYTE_COUNT_LSB = 3;
	localparam int MAX_PACKET_LEN_LSB = 18;
	localparam int ENDPOINT_LOW_BIT = 31;

	// Routing and token word fields
	localparam int ENDPOINT_HIGH_LSB = 0;
	localparam int FUNCTION_ADDR_LSB = 3;
	localparam int TOKEN_LSB = 10;
	localparam int TRANSFER_TYPE_LSB = 12;
	localparam int SPLIT_SELECT_BIT = 14;
	localparam int SPEED_END_LSB = 16;
	localparam int TRANSLATOR_PORT_LSB = 18;
	localparam int TRANSLATOR_HUB_LSB = 25;

	// Buffer and interval word fields
	localparam int INTERVAL_CODE_LSB = 3;
	localparam int BUFFER_START_LSB = 8;

	// Transfer status word fields
	localparam int BYTES_DONE_LSB = 0;
	localparam int ERROR_COUNT_LSB = 23;
	localparam int XACT_ERROR_BIT = 28;
	localparam int HALT_BIT = 30;
	localparam int ACTIVE_BIT = 31;

	// Encodings
	localparam logic [1:0] TOKEN_OUT = 2'h0;
	localparam logic [1:0] TOKEN_IN = 2'h1;
	localparam logic [1:0] TYPE_INTERRUPT = 2'h3;
	localparam logic [4:0] INTERVAL_CODE_MIN = 5'h04;
	localparam logic [4:0] INTERVAL_CODE_MAX = 5'h10;
	localparam logic [10:0] SPLIT_PACKET_MAX = 11'h040;
	localparam logic [14:0] BYTE_COUNT_MAX = 15'h1000;

	// Reset values
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [1:0] ERROR_COUNT_RESET = 2'h0;

	// Microframe timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int UFRAME_TIME_NS = 125000;
	localparam int UFRAME_CYCLES = UFRAME_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SCHED_IDLE,
		SCHED_WAIT_SLOT,
		SCHED_BUSY
	} sched_state_t;

endpackage

//--- split_interrupt_descriptor_decode.sv
// Interrupt transfer descriptor decoder with periodic scheduler, split aware.
// Assumes a classic Wishbone master and a transaction engine on core_clk
// that answers each txn_req with one txn_done pulse.
//
// Functional notes
// - Buffer start is internal memory address
// - Interval code is microframe bits 7:3
// - Run every 2^(b-1) microframes, b 4..16
// - Hub address routes the split transaction
// - Port field names translator port
// - Speed/end code only used for splits
// - Split bit selects split or high-speed
// - Token 00 is OUT, 01 is IN
// - Device address selects target function
// - Endpoint is three high plus one low
// - Packets limited by max length, 64 split
// - Byte count is total depth, 4 kB max
// - Clear valid on completion or fatal error
// - Error counter decrements per retry; 00 none
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module split_interrupt_descriptor_decode #(
	parameter int UFRAME_CYCLES = split_intr_pkg::UFRAME_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic txn_done,
	input wire logic txn_error,
	input wire logic [10:0] txn_bytes,
	output logic txn_req,
	output logic [1:0] txn_pid,
	output logic txn_split,
	output logic [1:0] speed_end_code,
	output logic [6:0] translator_hub_addr,
	output logic [6:0] translator_port,
	output logic [6:0] function_addr,
	output logic [3:0] endpoint_num,
	output logic [10:0] txn_len,
	output logic [15:0] mem_addr,
	output logic desc_done
);

	typedef struct packed {
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [31:0] length_and_valid_word;
		logic [31:0] routing_and_token_word;
		logic [31:0] buffer_and_interval_word;
		logic active;
		logic halt;
		logic xact_err;
		logic [1:0] err_count;
		logic [14:0] bytes_done;
		logic [15:0] uframe_div;
		logic [15:0] uframe_num;
		split_intr_pkg::sched_state_t state;
		logic txn_req;
		logic [1:0] pid;
		logic split;
		logic [1:0] speed_end;
		logic [6:0] hub;
		logic [6:0] port;
		logic [6:0] fn;
		logic [3:0] ep;
		logic [10:0] len;
		logic [15:0] addr;
		logic done;
	} state_t;

	state_t cur;
	state_t next_cur;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Decoded descriptor fields
	logic valid;
	logic [14:0] byte_count;
	logic [10:0] max_packet_len;
	logic [4:0] interval_code;
	logic [4:0] code_eff;
	logic [15:0] slot_mask;
	logic [15:0] buffer_start_addr;
	logic [14:0] total_bytes;
	logic [14:0] remaining;
	logic [10:0] packet_limit;
	logic [10:0] next_len;
	logic [14:0] new_done;
	logic uframe_tick;
	logic slot_hit;
	logic bus_req;
	logic [31:0] status_word;

	assign valid = cur.length_and_valid_word[split_intr_pkg::VALID_BIT];
	assign byte_count = cur.length_and_valid_word[split_intr_pkg::BYTE_COUNT_LSB +: 15];
	assign max_packet_len = cur.length_and_valid_word[split_intr_pkg::MAX_PACKET_LEN_LSB +: 11];
	assign interval_code = cur.buffer_and_interval_word[split_intr_pkg::INTERVAL_CODE_LSB +: 5];
	assign buffer_start_addr = cur.buffer_and_interval_word[split_intr_pkg::BUFFER_START_LSB +: 16];
	assign bus_req = wb_cyc_i && wb_stb_i && !cur.wb_ack;

	// Codes outside 4..16 are clamped rather than left to wrap the mask
	always_comb begin
		if (interval_code < split_intr_pkg::INTERVAL_CODE_MIN) begin
			code_eff = split_intr_pkg::INTERVAL_CODE_MIN;
		end else if (interval_code > split_intr_pkg::INTERVAL_CODE_MAX) begin
			code_eff = split_intr_pkg::INTERVAL_CODE_MAX;
		end else begin
			code_eff = interval_code;
		end
	end

	assign slot_mask = 16'((32'h1 << (code_eff - 5'h01)) - 32'h1);
	assign uframe_tick = (cur.uframe_div == 16'(UFRAME_CYCLES - 1));
	assign slot_hit = uframe_tick && ((cur.uframe_num & slot_mask) == 16'h0000);

	// Larger counts than 4 kB are cut to 4 kB
	assign total_bytes = (byte_count > split_intr_pkg::BYTE_COUNT_MAX) ?
		split_intr_pkg::BYTE_COUNT_MAX : byte_count;
	assign remaining = total_bytes - cur.bytes_done;
	assign packet_limit = (cur.routing_and_token_word[split_intr_pkg::SPLIT_SELECT_BIT] &&
		max_packet_len > split_intr_pkg::SPLIT_PACKET_MAX) ?
		split_intr_pkg::SPLIT_PACKET_MAX : max_packet_len;
	assign next_len = (remaining < 15'(packet_limit)) ? remaining[10:0] : packet_limit;
	assign new_done = cur.bytes_done + 15'(txn_bytes);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[split_intr_pkg::ACTIVE_BIT] = cur.active;
		status_word[split_intr_pkg::HALT_BIT] = cur.halt;
		status_word[split_intr_pkg::XACT_ERROR_BIT] = cur.xact_err;
		status_word[split_intr_pkg::ERROR_COUNT_LSB +: 2] = cur.err_count;
		status_word[split_intr_pkg::BYTES_DONE_LSB +: 15] = cur.bytes_done;
	end

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.uframe_div = uframe_tick ? 16'h0000 : cur.uframe_div + 16'h0001;
		next_cur.uframe_num = uframe_tick ? cur.uframe_num + 16'h0001 : cur.uframe_num;

		unique case (cur.state)
			split_intr_pkg::SCHED_IDLE: begin
				// Invalid descriptors are never touched here
				if (valid) begin
					next_cur.state = split_intr_pkg::SCHED_WAIT_SLOT;
					next_cur.bytes_done = 15'h0000;
					next_cur.addr = buffer_start_addr;
				end
			end
			split_intr_pkg::SCHED_WAIT_SLOT: begin
				if (!valid) begin
					next_cur.state = split_intr_pkg::SCHED_IDLE;
				end else if (slot_hit) begin
					next_cur.state = split_intr_pkg::SCHED_BUSY;
					next_cur.txn_req = 1'b1;
					next_cur.pid = cur.routing_and_token_word[split_intr_pkg::TOKEN_LSB +: 2];
					next_cur.split = cur.routing_and_token_word[split_intr_pkg::SPLIT_SELECT_BIT];
					// Speed/end bits mean nothing on a plain high-speed transaction
					next_cur.speed_end = next_cur.split ?
						cur.routing_and_token_word[split_intr_pkg::SPEED_END_LSB +: 2] :
						2'h0;
					next_cur.hub = cur.routing_and_token_word[split_intr_pkg::TRANSLATOR_HUB_LSB +: 7];
					next_cur.port = cur.routing_and_token_word[split_intr_pkg::TRANSLATOR_PORT_LSB +: 7];
					next_cur.fn = cur.routing_and_token_word[split_intr_pkg::FUNCTION_ADDR_LSB +: 7];
					next_cur.ep = {cur.routing_and_token_word[split_intr_pkg::ENDPOINT_HIGH_LSB +: 3],
						cur.length_and_valid_word[split_intr_pkg::ENDPOINT_LOW_BIT]};
					next_cur.len = next_len;
				end
			end
			split_intr_pkg::SCHED_BUSY: begin
				if (txn_done) begin
					next_cur.txn_req = 1'b0;
					next_cur.state = split_intr_pkg::SCHED_WAIT_SLOT;
					if (txn_error) begin
						next_cur.xact_err = 1'b1;
						if (cur.err_count == 2'h0) begin
							// Retries exhausted: fatal
							next_cur.length_and_valid_word[split_intr_pkg::VALID_BIT] = 1'b0;
							next_cur.active = 1'b0;
							next_cur.halt = 1'b1;
							next_cur.done = 1'b1;
							next_cur.state = split_intr_pkg::SCHED_IDLE;
						end else begin
							next_cur.err_count = cur.err_count - 2'h1;
						end
					end else begin
						next_cur.bytes_done = new_done;
						next_cur.addr = cur.addr + 16'(txn_bytes);
						if (new_done >= total_bytes) begin
							next_cur.length_and_valid_word[split_intr_pkg::VALID_BIT] = 1'b0;
							next_cur.active = 1'b0;
							next_cur.done = 1'b1;
							next_cur.state = split_intr_pkg::SCHED_IDLE;
						end
					end
				end
			end
		endcase

		// Bus access last, so a software set beats a same-cycle hardware clear
		next_cur.wb_ack = bus_req;
		next_cur.wb_dat = 32'h0000_0000;
		if (bus_req) begin
			if (wb_we_i) begin
				unique case (wb_adr_i)
					split_intr_pkg::LENGTH_AND_VALID_OFS: begin
						next_cur.length_and_valid_word =
							merge(cur.length_and_valid_word, wb_dat_i, wb_sel_i);
					end
					split_intr_pkg::ROUTING_AND_TOKEN_OFS: begin
						next_cur.routing_and_token_word =
							merge(cur.routing_and_token_word, wb_dat_i, wb_sel_i);
					end
					split_intr_pkg::BUFFER_AND_INTERVAL_OFS: begin
						next_cur.buffer_and_interval_word =
							merge(cur.buffer_and_interval_word, wb_dat_i, wb_sel_i);
					end
					split_intr_pkg::TRANSFER_STATUS_OFS: begin
						if (wb_sel_i[3]) begin
							next_cur.active = wb_dat_i[split_intr_pkg::ACTIVE_BIT];
							next_cur.halt = wb_dat_i[split_intr_pkg::HALT_BIT];
							next_cur.xact_err = wb_dat_i[split_intr_pkg::XACT_ERROR_BIT];
						end
						if (wb_sel_i[2]) begin
							next_cur.err_count = wb_dat_i[split_intr_pkg::ERROR_COUNT_LSB +: 2];
						end
					end
					default: begin
					end
				endcase
			end else begin
				unique case (wb_adr_i)
					split_intr_pkg::LENGTH_AND_VALID_OFS: next_cur.wb_dat = cur.length_and_valid_word;
					split_intr_pkg::ROUTING_AND_TOKEN_OFS: next_cur.wb_dat = cur.routing_and_token_word;
					split_intr_pkg::BUFFER_AND_INTERVAL_OFS: next_cur.wb_dat = cur.buffer_and_interval_word;
					split_intr_pkg::TRANSFER_STATUS_OFS: next_cur.wb_dat = status_word;
					default: next_cur.wb_dat = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
			cur.length_and_valid_word <= split_intr_pkg::WORD_RESET;
			cur.routing_and_token_word <= split_intr_pkg::WORD_RESET;
			cur.buffer_and_interval_word <= split_intr_pkg::WORD_RESET;
			cur.err_count <= split_intr_pkg::ERROR_COUNT_RESET;
			cur.state <= split_intr_pkg::SCHED_IDLE;
		end else begin
			cur <= next_cur;
		end
	end

	assign wb_ack_o = cur.wb_ack;
	assign wb_dat_o = cur.wb_dat;
	assign txn_req = cur.txn_req;
	assign txn_pid = cur.pid;
	assign txn_split = cur.split;
	assign speed_end_code = cur.speed_end;
	assign translator_hub_addr = cur.hub;
	assign translator_port = cur.port;
	assign function_addr = cur.fn;
	assign endpoint_num = cur.ep;
	assign txn_len = cur.len;
	assign mem_addr = cur.addr;
	assign desc_done = cur.done;

endmodule // split_interrupt_descriptor_decode

//--- split_interrupt_descriptor_decode_properties.sv
// Port-level assertions for the split interrupt descriptor decoder.
// Assumes binding to the decoder; sees only its ports.
`timescale 1ns/10ps
module split_interrupt_descriptor_decode_properties #(
	parameter int UFRAME_CYCLES = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic txn_done,
	input wire logic txn_error,
	input wire logic [10:0] txn_bytes,
	input wire logic txn_req,
	input wire logic [1:0] txn_pid,
	input wire logic txn_split,
	input wire logic [1:0] speed_end_code,
	input wire logic [10:0] txn_len,
	input wire logic [15:0] mem_addr,
	input wire logic desc_done
);
	localparam int MIN_GAP = 8 * UFRAME_CYCLES;
	logic req_q;
	int gap;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Saturating count of cycles since the last request began
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_q <= 1'b0;
			gap <= MIN_GAP;
		end else begin
			req_q <= txn_req;
			gap <= (txn_req && !req_q) ? 1 : gap + ((gap < MIN_GAP) ? 1 : 0);
		end
	end
	chk_slot_gap: assert property (txn_req && !req_q |-> gap >= MIN_GAP)
		else $error("requests closer than eight microframes");
	chk_fields_hold: assert property (txn_req && !txn_done |=> txn_req && $stable(txn_len)
		&& $stable(mem_addr) && $stable(txn_pid)) else $error("request changed before done");
	chk_req_release: assert property (txn_req && txn_done |=> !txn_req)
		else $error("request held after done");
	chk_hs_speed: assert property (txn_req && !txn_split |-> speed_end_code == 2'h0)
		else $error("speed code set without split");
	chk_split_len: assert property (txn_req && txn_split |-> txn_len <= 11'h040)
		else $error("split packet above 64 bytes");
	chk_done_cause: assert property (desc_done |-> $past(txn_done) && $past(txn_req))
		else $error("descriptor done without transfer");
	chk_done_pulse: assert property (desc_done |=> !desc_done)
		else $error("done longer than one cycle");
	chk_addr_step: assert property (txn_req && txn_done && !txn_error |=>
		mem_addr == $past(mem_addr) + 16'($past(txn_bytes))) else $error("address step wrong");
	chk_addr_retry: assert property (txn_req && txn_done && txn_error |=> $stable(mem_addr))
		else $error("address moved on failure");
	cov_split: cover property (txn_req && txn_split);
	cov_retry: cover property (txn_done && txn_error);
	cov_done: cover property (desc_done);
endmodule // split_interrupt_descriptor_decode_properties
bind split_interrupt_descriptor_decode split_interrupt_descriptor_decode_properties #(
	.UFRAME_CYCLES(UFRAME_CYCLES)
) i_split_interrupt_descriptor_decode_properties (
	.core_clk(core_clk), .reset_n(reset_n), .txn_done(txn_done), .txn_error(txn_error),
	.txn_bytes(txn_bytes), .txn_req(txn_req), .txn_pid(txn_pid), .txn_split(txn_split),
	.speed_end_code(speed_end_code), .txn_len(txn_len), .mem_addr(mem_addr),
	.desc_done(desc_done)
);

//--- txn_engine_model.sv
// Stand-in for the transaction engine and the hub behind it.
// Assumes the decoder holds txn_req until it samples txn_done.
`timescale 1ns/10ps
module txn_engine_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic txn_req,
	input wire logic [10:0] txn_len,
	input wire logic [7:0] delay,
	input wire logic fail,
	output logic txn_done,
	output logic txn_error,
	output logic [10:0] txn_bytes
);
	int cnt;
	logic answered;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			answered <= 1'b0;
			txn_done <= 1'b0;
			txn_error <= 1'b0;
			txn_bytes <= 11'h000;
		end else begin
			// Outside an answer txn_error and txn_bytes churn, never hold; txn_done stays low
			txn_done <= 1'b0;
			txn_error <= ~txn_error;
			txn_bytes <= ~txn_bytes;
			if (!txn_req) begin
				answered <= 1'b0;
				cnt <= 0;
			end else if (!answered && cnt >= int'(delay)) begin
				answered <= 1'b1;
				txn_done <= 1'b1;
				txn_error <= fail;
				txn_bytes <= txn_len;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule // txn_engine_model

//--- split_interrupt_descriptor_decode_tb_top.sv
// Self-checking bench for the split interrupt descriptor decoder.
// Assumes the engine model on the far side and a short microframe.
`timescale 1ns/10ps
module split_interrupt_descriptor_decode_tb_top;
	localparam int UF = 8;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd, w;
	logic wb_ack_o, txn_done, txn_error, txn_req, txn_split, desc_done;
	logic [10:0] txn_bytes, txn_len;
	logic [1:0] txn_pid, speed_end_code;
	logic [6:0] hub, port, fn;
	logic [3:0] ep;
	logic [15:0] mem_addr;
	logic [7:0] slow = 8'h00;
	logic fail_txn = 1'b0;
	logic [31:0] seed = 32'h0000_2B41;
	int num_errors = 0;
	int tests_run = 0;
	int dones = 0;
	split_interrupt_descriptor_decode #(.UFRAME_CYCLES(UF)) i_split_interrupt_descriptor_decode (
		.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txn_done(txn_done), .txn_error(txn_error),
		.txn_bytes(txn_bytes), .txn_req(txn_req), .txn_pid(txn_pid), .txn_split(txn_split),
		.speed_end_code(speed_end_code), .translator_hub_addr(hub), .translator_port(port),
		.function_addr(fn), .endpoint_num(ep), .txn_len(txn_len), .mem_addr(mem_addr),
		.desc_done(desc_done));
	txn_engine_model i_txn_engine_model (.core_clk(core_clk), .reset_n(reset_n),
		.txn_req(txn_req), .txn_len(txn_len), .delay(slow), .fail(fail_txn),
		.txn_done(txn_done), .txn_error(txn_error), .txn_bytes(txn_bytes));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (desc_done === 1'b1) dones++;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic we, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, s, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			chk("bus ack", 1, 0);
			report_and_stop();
		end
		rd = wb_dat_o;
		{wb_cyc, wb_stb} <= 2'b00;
	endtask
	task automatic wait_req(input logic lvl);
		int n;
		n = 0;
		while (txn_req !== lvl) begin
			@(posedge core_clk);
			if (++n > 3000) begin
				chk("request wait", lvl, txn_req);
				report_and_stop();
			end
		end
	endtask
	task automatic run_desc(input int b, input logic fail, input logic split);
		logic [31:0] w0, w1, w2, r;
		int bc, mpl, lim, rem, len, k, d0;
		longint t0;
		w1 = rnd();
		{w1[14:10]} = {split, split_intr_pkg::TYPE_INTERRUPT, 1'b0, 1'(b) ^ split};
		r = rnd();
		w2 = {8'h00, r[15:0], 5'(b), 3'h0};
		bc = 1 + int'(rnd() % 150);
		mpl = 40 + int'(rnd() % 60);
		w0 = (rnd() & 32'h8000_0000) | {3'h0, 11'(mpl), 15'(bc), 3'h1};
		lim = (split && mpl > 64) ? 64 : mpl;
		rem = bc;
		k = 0;
		d0 = dones;
		t0 = -1;
		wb(8'h04, 1'b1, 4'hF, w1);
		wb(8'h08, 1'b1, 4'hF, w2);
		wb(8'h0C, 1'b1, 4'hC, fail ? 32'h8080_0000 : 32'h8000_0000);
		wb(8'h00, 1'b1, 4'hF, w0);
		while (fail ? k < 2 : rem > 0) begin
			wait_req(1'b1);
			len = rem < lim ? rem : lim;
			chk("txn_len", len, txn_len);
			chk("mem_addr", 16'(r[15:0] + bc - rem), mem_addr);
			chk("pid", w1[11:10], txn_pid);
			chk("split", split, txn_split);
			chk("speed", split ? w1[17:16] : 2'h0, speed_end_code);
			chk("hub", w1[31:25], hub);
			chk("port", w1[24:18], port);
			chk("function", w1[9:3], fn);
			chk("endpoint", {w1[2:0], w0[31]}, ep);
			if (t0 >= 0) chk("slot gap", (1 << (b - 1)) * UF, int'(($time - t0) / 20));
			t0 = $time;
			if (!fail) rem -= len;
			k++;
			wait_req(1'b0);
		end
		repeat (2) @(posedge core_clk);
		chk("done pulses", d0 + 1, dones);
		wb(8'h00, 1'b0, 4'hF, 32'h0);
		chk("valid word", w0 & 32'hFFFF_FFFE, rd);
		wb(8'h0C, 1'b0, 4'hF, 32'h0);
		chk("active halt", fail ? 2'h1 : 2'h0, rd[31:30]);
		chk("bytes done", fail ? 0 : bc, rd[14:0]);
		chk("error count", 0, rd[24:23]);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 20; a += 4) begin
			wb(8'(a), 1'b0, 4'hF, 32'h0);
			chk("reset word", split_intr_pkg::WORD_RESET, rd);
		end
		wb(8'h10, 1'b1, 4'hF, 32'hFFFF_FFFF);
		wb(8'h10, 1'b0, 4'hF, 32'h0);
		chk("unmapped", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			slow <= 8'(i * 7);
			run_desc(4 + i % 2, 1'b0, i[1]);
		end
		fail_txn <= 1'b1;
		run_desc(4, 1'b1, 1'b0);
		fail_txn <= 1'b0;
		w = rnd() & 32'hFFFF_FFFE;
		wb(8'h00, 1'b1, 4'hF, w);
		repeat (200) begin
			@(posedge core_clk);
			chk("idle request", 0, txn_req);
		end
		wb(8'h00, 1'b0, 4'hF, 32'h0);
		chk("idle word", w, rd);
		report_and_stop();
	end
endmodule // split_interrupt_descriptor_decode_tb_top
